/* verilog/mts_map.svh */
// register offsets, field positions, reset values and timing counts of the trigger sequencer
`ifndef MTS_MAP_SVH
`define MTS_MAP_SVH
`define MTS_CLK_MHZ 100
`define MTS_ADDR_CTRL 8'h00
`define MTS_ADDR_CMD 8'h04
`define MTS_ADDR_POL 8'h08
`define MTS_ADDR_INSRC 8'h0C
`define MTS_ADDR_OUTDST 8'h10
`define MTS_ADDR_FORM 8'h14
`define MTS_ADDR_HOLD 8'h18
`define MTS_ADDR_MDLY 8'h1C
`define MTS_ADDR_SDLY 8'h20
`define MTS_ADDR_STAT 8'h24
`define MTS_ADDR_DONE 8'h28
`define MTS_CMD_TIMED 0
`define MTS_CMD_TIMED_PORT 1
`define MTS_CMD_TRIG 2
`define MTS_CMD_TRIG_PORT 3
`define MTS_CMD_FIRE 4
`define MTS_CMD_FIRE_SEL 5
`define MTS_CMD_RUN 6
`define MTS_CMD_HALT 7
`define MTS_CMD_CLEAR 8
`define MTS_POL_RESET 4'h0
`define MTS_INSRC_RESET 20'h00000
`define MTS_FORM_RESET 3'h0
`define MTS_EDGE_US 10
`define MTS_PULSE_US 100
`define MTS_PULSE_LEAD_US 110
`define MTS_LEAD_US 10
`define MTS_HOLD_RES_US 100
`define MTS_EDGE_CYC (`MTS_EDGE_US * `MTS_CLK_MHZ)
`define MTS_PULSE_CYC (`MTS_PULSE_US * `MTS_CLK_MHZ)
`define MTS_PLS_TRIG_CYC ((`MTS_PULSE_LEAD_US - `MTS_LEAD_US) * `MTS_CLK_MHZ)
`define MTS_HOLD_RES_CYC (`MTS_HOLD_RES_US * `MTS_CLK_MHZ)
`endif

/* verilog/mts_pkg.sv */
// types of the trigger sequencer
package mts_pkg;
  typedef enum logic [1:0] {MTS_IN_START, MTS_IN_SETUP, MTS_IN_STEP, MTS_IN_HOLD} mts_in_t;
  typedef enum {MTS_IDLE, MTS_TIMED, MTS_TRIGW} mts_wait_t;
endpackage

/* verilog/mts_trigger_seq.sv */
// trigger sequencer: input triggers, output triggers and wait states
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mts_map.svh"
module mts_trigger_seq
  import mts_pkg::*;
#(
  parameter int NCH = 4,
  parameter int NIO = 16
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic MAIN_TRIG_I,
  output logic MAIN_TRIG_O,
  input wire logic [NIO-1:0] GIO_I,
  output logic [NIO-1:0] GIO_O,
  output logic [NIO-1:0] GIO_OE_O,
  input wire logic [NCH-1:0] MEAS_DONE_I,
  input wire logic [NCH-1:0] SETUP_DONE_I,
  input wire logic [NCH-1:0] STEP_DONE_I,
  input wire logic [NCH-1:0] CH_USED_I,
  input wire logic PULSED_I,
  output logic START_MEAS_O,
  output logic START_SETUP_O,
  output logic START_STEP_O,
  output logic PULSE_GO_O,
  output logic HOLD_BUSY_O
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [3:0] pol_reg;
  logic [19:0] insrc_reg;
  logic [19:0] outdst_reg;
  logic [2:0] form_reg;
  logic [1:0] ctrl_reg;
  logic [20:0] hold_reg;
  logic [23:0] mdly_reg;
  logic [23:0] sdly_reg;
  logic [2:0] done_reg;
  logic [NIO:0] s1_reg;
  logic [NIO:0] s2_reg;
  logic [NIO:0] s3_reg;
  logic [2:0] trig_edge;
  mts_wait_t wait_reg;
  logic hold_port_reg;
  logic [3:0] hold_in_sel;
  logic [19:0] hold_cnt_reg;
  logic [13:0] hold_pre_reg;
  logic [23:0] mcnt_reg;
  logic mbusy_reg;
  logic [23:0] scnt_reg;
  logic sbusy_reg;
  logic [13:0] pcnt_reg;
  logic pbusy_reg;
  logic [NCH-1:0] meas_seen_reg;
  logic [NCH-1:0] setup_seen_reg;
  logic [NCH-1:0] step_seen_reg;
  logic [2:0] ev;
  logic [15:0] ocnt_reg [0:2];
  logic [2:0] gate_reg;
  logic fire_reg;
  logic [3:0] fire_port_reg;
  logic [15:0] fire_cnt_reg;
  logic [2:0] o_act;
  logic [NIO:0] o_line;
  logic [NIO:0] o_en;
  logic cmd;
  assign cmd = CE_I && WR_I && (ADDR_I == `MTS_ADDR_CMD);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pol_reg <= `MTS_POL_RESET;
      insrc_reg <= `MTS_INSRC_RESET;
      outdst_reg <= 20'h00000;
      form_reg <= `MTS_FORM_RESET;
      ctrl_reg <= 2'h0;
      hold_reg <= 21'h000000;
      mdly_reg <= 24'h000000;
      sdly_reg <= 24'h000000;
    end else if (CE_I && WR_I) begin
      case (ADDR_I)
        `MTS_ADDR_POL: pol_reg <= WDATA_I[3:0];
        `MTS_ADDR_INSRC: insrc_reg <= WDATA_I[19:0];
        `MTS_ADDR_OUTDST: outdst_reg <= WDATA_I[19:0];
        `MTS_ADDR_FORM: form_reg <= WDATA_I[2:0];
        `MTS_ADDR_CTRL: ctrl_reg <= WDATA_I[1:0];
        `MTS_ADDR_HOLD: hold_reg <= WDATA_I[20:0];
        `MTS_ADDR_MDLY: mdly_reg <= WDATA_I[23:0];
        `MTS_ADDR_SDLY: sdly_reg <= WDATA_I[23:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RDATA_O <= 32'h00000000;
    end else if (CE_I && RD_I) begin
      case (ADDR_I)
        `MTS_ADDR_CTRL: RDATA_O <= {30'h0, ctrl_reg};
        `MTS_ADDR_POL: RDATA_O <= {28'h0, pol_reg};
        `MTS_ADDR_INSRC: RDATA_O <= {12'h0, insrc_reg};
        `MTS_ADDR_OUTDST: RDATA_O <= {12'h0, outdst_reg};
        `MTS_ADDR_FORM: RDATA_O <= {29'h0, form_reg};
        `MTS_ADDR_HOLD: RDATA_O <= {11'h0, hold_reg};
        `MTS_ADDR_MDLY: RDATA_O <= {8'h0, mdly_reg};
        `MTS_ADDR_SDLY: RDATA_O <= {8'h0, sdly_reg};
        `MTS_ADDR_STAT: RDATA_O <= {26'h0, gate_reg, HOLD_BUSY_O, mbusy_reg, sbusy_reg};
        `MTS_ADDR_DONE: RDATA_O <= {29'h0, done_reg};
        default: RDATA_O <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // input synchronisers; index 0 is the main input, 1..NIO the lines
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
    end else if (CE_I) begin
      s1_reg <= {GIO_I, MAIN_TRIG_I};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // per input kind: start, setup, step; the hold input uses pol bit 3
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_in
      logic [4:0] sel;
      logic [NIO:0] act;
      logic [NIO:0] act_d;
      assign sel = insrc_reg[g*5 +: 5];
      // negative logic sees a high-to-low change as the trigger
      assign act = pol_reg[g] ? s2_reg : ~s2_reg;
      assign act_d = pol_reg[g] ? s3_reg : ~s3_reg;
      assign trig_edge[g] = act[sel] && !act_d[sel];
    end
  endgenerate
  logic hold_edge;
  logic [4:0] hsel;
  assign hsel = hold_port_reg ? insrc_reg[19:15] : 5'h00;
  assign hold_edge = (pol_reg[3] ? s2_reg[hsel] : ~s2_reg[hsel]) &&
                     !(pol_reg[3] ? s3_reg[hsel] : ~s3_reg[hsel]);
  assign START_MEAS_O = CE_I && trig_edge[0];
  assign START_SETUP_O = CE_I && trig_edge[1];

  // ----------------------------------------------------------------
  // wait states
  // ----------------------------------------------------------------
  logic release_ev;
  assign release_ev = ctrl_reg[0] && (hold_edge ||
                      (cmd && WDATA_I[`MTS_CMD_RUN]));
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wait_reg <= MTS_IDLE;
      hold_port_reg <= 1'b0;
      hold_cnt_reg <= 20'h0;
      hold_pre_reg <= 14'h0;
    end else if (CE_I) begin
      case (wait_reg)
        MTS_IDLE: begin
          if (cmd && (WDATA_I[`MTS_CMD_TIMED] || WDATA_I[`MTS_CMD_TIMED_PORT])) begin
            wait_reg <= MTS_TIMED;
            hold_port_reg <= WDATA_I[`MTS_CMD_TIMED_PORT];
            hold_cnt_reg <= hold_reg[19:0];
            hold_pre_reg <= 14'h0;
          end else if (cmd && (WDATA_I[`MTS_CMD_TRIG] || WDATA_I[`MTS_CMD_TRIG_PORT])) begin
            wait_reg <= MTS_TRIGW;
            hold_port_reg <= WDATA_I[`MTS_CMD_TRIG_PORT];
          end
        end
        MTS_TIMED: begin
          // negative time means no timeout at all
          if (release_ev) begin
            wait_reg <= MTS_IDLE;
          end else if (!hold_reg[20]) begin
            if (hold_cnt_reg == 20'h0) begin
              wait_reg <= MTS_IDLE;
            end else if (hold_pre_reg == 14'(`MTS_HOLD_RES_CYC - 1)) begin
              hold_pre_reg <= 14'h0;
              hold_cnt_reg <= hold_cnt_reg - 20'h1;
            end else begin
              hold_pre_reg <= hold_pre_reg + 14'h1;
            end
          end
        end
        MTS_TRIGW: begin
          // run command does not release a trigger hold
          if (hold_edge) begin
            wait_reg <= MTS_IDLE;
          end else if (cmd && (WDATA_I[`MTS_CMD_HALT] || WDATA_I[`MTS_CMD_CLEAR])) begin
            wait_reg <= MTS_IDLE;
          end
        end
        default: wait_reg <= MTS_IDLE;
      endcase
    end
  end
  assign HOLD_BUSY_O = (wait_reg != MTS_IDLE);

  // ----------------------------------------------------------------
  // delays: measurement delay, source delay, pulse lead
  // ----------------------------------------------------------------
  logic all_setup;
  assign all_setup = &(setup_seen_reg | SETUP_DONE_I | ~CH_USED_I);
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mbusy_reg <= 1'b0;
      mcnt_reg <= 24'h0;
      sbusy_reg <= 1'b0;
      scnt_reg <= 24'h0;
      pbusy_reg <= 1'b0;
      pcnt_reg <= 14'h0;
      START_STEP_O <= 1'b0;
      PULSE_GO_O <= 1'b0;
      setup_seen_reg <= '0;
      meas_seen_reg <= '0;
      step_seen_reg <= '0;
      ev <= 3'h0;
    end else if (CE_I) begin
      START_STEP_O <= 1'b0;
      PULSE_GO_O <= 1'b0;
      ev <= 3'h0;
      if (trig_edge[2]) begin
        mbusy_reg <= 1'b1;
        mcnt_reg <= mdly_reg;
      end else if (mbusy_reg) begin
        if (mcnt_reg == 24'h0) begin
          mbusy_reg <= 1'b0;
          START_STEP_O <= 1'b1;
        end else begin
          mcnt_reg <= mcnt_reg - 24'h1;
        end
      end
      if (trig_edge[1] && PULSED_I) begin
        pbusy_reg <= 1'b1;
        pcnt_reg <= 14'h0;
      end else if (pbusy_reg) begin
        if (pcnt_reg == 14'(`MTS_PLS_TRIG_CYC - 1)) begin
          ev[1] <= 1'b1;
        end
        if (pcnt_reg == 14'(`MTS_PLS_TRIG_CYC + `MTS_LEAD_US * `MTS_CLK_MHZ - 1)) begin
          pbusy_reg <= 1'b0;
          PULSE_GO_O <= 1'b1;
        end else begin
          pcnt_reg <= pcnt_reg + 14'h1;
        end
      end
      setup_seen_reg <= setup_seen_reg | SETUP_DONE_I;
      if (all_setup && |(setup_seen_reg | SETUP_DONE_I) && !PULSED_I) begin
        setup_seen_reg <= '0;
        sbusy_reg <= 1'b1;
        scnt_reg <= sdly_reg;
      end else if (sbusy_reg) begin
        if (scnt_reg == 24'h0) begin
          sbusy_reg <= 1'b0;
          ev[1] <= 1'b1;
        end else begin
          scnt_reg <= scnt_reg - 24'h1;
        end
      end
      meas_seen_reg <= meas_seen_reg | MEAS_DONE_I;
      if (&(meas_seen_reg | MEAS_DONE_I | ~CH_USED_I) && |(meas_seen_reg | MEAS_DONE_I)) begin
        meas_seen_reg <= '0;
        ev[0] <= 1'b1;
      end
      step_seen_reg <= step_seen_reg | STEP_DONE_I;
      if (&(step_seen_reg | STEP_DONE_I | ~CH_USED_I) && |(step_seen_reg | STEP_DONE_I)) begin
        step_seen_reg <= '0;
        ev[2] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // output triggers: edge pulse on completion, or gate ended on completion
  // ----------------------------------------------------------------
  logic [15:0] width;
  assign width = PULSED_I ? 16'(`MTS_PULSE_CYC) : 16'(`MTS_EDGE_CYC);
  generate
    for (g = 0; g < 3; g++) begin : g_out
      // gate rises when the operation starts, falls when it completes
      logic start_op;
      assign start_op = (g == 0) ? trig_edge[0] : (g == 1) ? trig_edge[1] : trig_edge[2];
      always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
          ocnt_reg[g] <= 16'h0;
          gate_reg[g] <= 1'b0;
        end else if (CE_I) begin
          if (form_reg[g]) begin
            if (ev[g]) begin
              gate_reg[g] <= 1'b0;
            end else if (start_op) begin
              gate_reg[g] <= 1'b1;
            end
          end else if (ev[g]) begin
            ocnt_reg[g] <= width;
          end else if (ocnt_reg[g] != 16'h0) begin
            ocnt_reg[g] <= ocnt_reg[g] - 16'h1;
          end
        end
      end
      assign o_act[g] = form_reg[g] ? gate_reg[g] : (ocnt_reg[g] != 16'h0);
    end
  endgenerate

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      fire_cnt_reg <= 16'h0;
      fire_reg <= 1'b0;
    end else if (CE_I) begin
      if (cmd && (WDATA_I[`MTS_CMD_FIRE] || WDATA_I[`MTS_CMD_FIRE_SEL])) begin
        fire_cnt_reg <= 16'(`MTS_EDGE_CYC);
        fire_reg <= WDATA_I[`MTS_CMD_FIRE_SEL];
      end else if (fire_cnt_reg != 16'h0) begin
        fire_cnt_reg <= fire_cnt_reg - 16'h1;
      end
    end
  end

  always_comb begin
    o_line = '0;
    o_en = '0;
    for (int k = 0; k < 3; k++) begin
      o_line[outdst_reg[k*5 +: 5]] = o_line[outdst_reg[k*5 +: 5]] | o_act[k];
      o_en[outdst_reg[k*5 +: 5]] = 1'b1;
    end
    // fire uses main output, or the port in outdst bits 19:15
    o_line[fire_reg ? outdst_reg[19:15] : 5'h00] =
      o_line[fire_reg ? outdst_reg[19:15] : 5'h00] | (fire_cnt_reg != 16'h0);
    o_en[fire_reg ? outdst_reg[19:15] : 5'h00] = 1'b1;
  end

  // active output drives low under negative logic, where the idle level is high
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      MAIN_TRIG_O <= 1'b1;
      GIO_O <= '1;
      GIO_OE_O <= '0;
      done_reg <= 3'h0;
    end else if (CE_I) begin
      MAIN_TRIG_O <= pol_reg[0] ? o_line[0] : ~o_line[0];
      GIO_O <= pol_reg[1] ? o_line[NIO:1] : ~o_line[NIO:1];
      GIO_OE_O <= o_en[NIO:1];
      done_reg <= done_reg | ev;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  sequence s_halt;
    CE_I && cmd && WDATA_I[`MTS_CMD_HALT] && wait_reg == MTS_TRIGW;
  endsequence
  AST_HALT_ENDS_HOLD: assert property (s_halt |=> wait_reg == MTS_IDLE)
    else $error("halt did not end trigger hold");
  AST_RUN_NOT_TRIGW: assert property (CE_I && wait_reg == MTS_TRIGW && cmd &&
    WDATA_I == 32'h40 && !hold_edge |=> wait_reg == MTS_TRIGW)
    else $error("run command released trigger hold");
  AST_STEP_AFTER_DELAY: assert property (CE_I && trig_edge[2] && mdly_reg == 24'h2 &&
    ADDR_I != `MTS_ADDR_MDLY ##1 CE_I [*4] |-> START_STEP_O)
    else $error("step start not after measurement delay");
  AST_FIRE_IMMEDIATE: assert property (cmd && WDATA_I == 32'h10 |=> fire_cnt_reg != 16'h0)
    else $error("fire command did not fire");
  AST_TRIG_RELEASE: assert property (CE_I && wait_reg == MTS_TRIGW && hold_edge |=>
    !HOLD_BUSY_O)
    else $error("trigger did not release hold");
  AST_TIMED_EVENT: assert property (CE_I && wait_reg == MTS_TIMED && release_ev |=>
    wait_reg == MTS_IDLE)
    else $error("event did not release timed hold");
  AST_NEG_NO_TIMEOUT: assert property (CE_I && wait_reg == MTS_TIMED && hold_reg[20] &&
    !release_ev |=> wait_reg == MTS_TIMED)
    else $error("negative hold time timed out");
  AST_START_MEAS: assert property (START_MEAS_O && insrc_reg[4:0] == 5'h00 && !pol_reg[0] &&
    $past(CE_I) && $past(CE_I, 2) && $past(CE_I, 3) |-> !$past(MAIN_TRIG_I, 2) && $past(MAIN_TRIG_I, 3))
    else $error("measurement start without trigger edge");
endmodule
`default_nettype wire

/* verif/mts_equipment.sv */
// model of the external test equipment that trades trigger pulses
`timescale 1ns/1ps
`default_nettype none
module mts_equipment (
  input wire logic clk_i,
  input wire logic out_trig_i,
  output logic main_trig_o,
  output logic [15:0] gio_o
);
  int hold_cnt = 0;
  int sel = 0;
  int run = 0;
  int last_low = 0;
  // ------
  // pulses
  // ------
  // lines idle high as the pull-ups leave them; a pulse is active low
  assign main_trig_o = !(hold_cnt != 0 && sel == 0);
  always_comb begin
    gio_o = 16'hFFFF;
    if (hold_cnt != 0 && sel != 0) gio_o[sel-1] = 1'b0;
  end
  // width of the last low pulse seen on the device output
  always @(posedge clk_i) begin
    if (hold_cnt != 0) hold_cnt <= hold_cnt - 1;
    if (out_trig_i === 1'b0) run <= run + 1;
    else if (run != 0) begin
      last_low <= run;
      run <= 0;
    end
  end
  // line 0 is the main input, k the general line k; a gap lets the lines settle high
  task automatic send(input int line, input int width);
    while (hold_cnt != 0) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    sel <= line;
    hold_cnt <= width;
  endtask
endmodule
`default_nettype wire

/* verif/mts_trigger_seq_tb.sv */
// self-checking bench of the trigger sequencer
`timescale 1ns/1ps
`default_nettype none
`include "mts_map.svh"
module mts_trigger_seq_tb;
  localparam int EDGE = `MTS_EDGE_CYC;
  localparam int LEAD = `MTS_LEAD_US * `MTS_CLK_MHZ;
  logic clk, rst_n, ce, wr, rd, pulsed, main_in, main_out, hold_busy;
  logic start_meas, start_setup, start_step, pulse_go;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [15:0] gio_in, gio_out, gio_oe, eqp_gio;
  logic [3:0] meas_done, setup_done, step_done, ch_used;
  int failures = 0, n_tests = 0, n_meas = 0, n_setup = 0, n_step = 0, n_go = 0;
  int n, m;
  // bus wire: a line that the device drives wins over the equipment
  assign gio_in = (gio_oe & gio_out) | (~gio_oe & eqp_gio);
  mts_trigger_seq i_dut (.CLK_I(clk), .RSTN_I(rst_n), .CE_I(ce), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .MAIN_TRIG_I(main_in),
    .MAIN_TRIG_O(main_out), .GIO_I(gio_in), .GIO_O(gio_out), .GIO_OE_O(gio_oe),
    .MEAS_DONE_I(meas_done), .SETUP_DONE_I(setup_done), .STEP_DONE_I(step_done),
    .CH_USED_I(ch_used), .PULSED_I(pulsed), .START_MEAS_O(start_meas),
    .START_SETUP_O(start_setup), .START_STEP_O(start_step), .PULSE_GO_O(pulse_go),
    .HOLD_BUSY_O(hold_busy));
  mts_equipment i_eqp (.clk_i(clk), .out_trig_i(main_out), .main_trig_o(main_in),
    .gio_o(eqp_gio));
  // -----
  // tasks
  // -----
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic cmd(input int c);
    wr_reg(`MTS_ADDR_CMD, 32'h1 << c);
  endtask
  task automatic done(input int kind, input logic [3:0] mk);
    @(posedge clk);
    if (kind == 0) meas_done <= mk;
    else if (kind == 1) setup_done <= mk;
    else step_done <= mk;
    @(posedge clk);
    meas_done <= 4'h0;
    setup_done <= 4'h0;
    step_done <= 4'h0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask
  task automatic chk_in(input int got, input int lo, input int hi, input string msg);
    chk({31'h0, got >= lo && got <= hi}, 32'h1, msg);
  endtask
  // 16 is the main output, 17 the busy flag, others a general line
  function automatic logic probe(input int s);
    if (s == 16) return main_out;
    if (s == 17) return hold_busy;
    return gio_out[s];
  endfunction
  task automatic wait_lvl(input int s, input logic lvl, input int max, output int cnt);
    cnt = 0;
    while (probe(s) !== lvl && cnt < max) begin
      tick();
      cnt++;
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // --------------
  // clock and pulse counters
  // --------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (start_meas === 1'b1) n_meas <= n_meas + 1;
    if (start_setup === 1'b1) n_setup <= n_setup + 1;
    if (start_step === 1'b1) n_step <= n_step + 1;
    if (pulse_go === 1'b1) n_go <= n_go + 1;
  end
  initial begin
    repeat (95000) @(posedge clk);
    failures++;
    $display("wrong value at %0t ns: run hung", $time);
    give_verdict();
  end
  // -----
  // tests
  // -----
  initial begin
    {wr, rd, pulsed, addr, wdata} = '0;
    {meas_done, setup_done, step_done} = '0;
    ch_used = 4'h3;
    ce = 1'b1;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tick();
    chk(main_out, 32'h1, "main idle");
    chk(gio_oe, 32'h0, "lines released");
    chk(hold_busy, 32'h0, "not waiting");
    rd_reg(`MTS_ADDR_POL, d);
    chk(d, `MTS_POL_RESET, "polarity reset");
    rd_reg(`MTS_ADDR_INSRC, d);
    chk(d, `MTS_INSRC_RESET, "input map reset");
    rd_reg(`MTS_ADDR_FORM, d);
    chk(d, `MTS_FORM_RESET, "form reset");
    rd_reg(8'hFC, d);
    chk(d, 32'h0, "unmapped read");
    wr_reg(`MTS_ADDR_POL, 32'hF);
    rd_reg(`MTS_ADDR_POL, d);
    chk(d, 32'hF, "polarity set");
    wr_reg(`MTS_ADDR_POL, 32'h0);
    // fire, then wait for the main output to go low
    cmd(`MTS_CMD_FIRE);
    wait_lvl(16, 1'b0, 6, n);
    chk_in(n, 0, 5, "fire main");
    cmd(`MTS_CMD_TRIG);
    cmd(`MTS_CMD_RUN);
    tick();
    chk(hold_busy, 32'h1, "hold kept");
    wait_lvl(16, 1'b1, EDGE + 10, n);
    tick();
    chk_in(i_eqp.last_low, EDGE - 2, EDGE + 2, "edge width");
    i_eqp.send(0, EDGE);
    wait_lvl(17, 1'b0, 10, n);
    chk_in(n, 0, 9, "hold released");
    cmd(`MTS_CMD_TRIG);
    cmd(`MTS_CMD_HALT);
    wait_lvl(17, 1'b0, 5, n);
    chk_in(n, 0, 4, "halt");
    cmd(`MTS_CMD_TRIG);
    cmd(`MTS_CMD_CLEAR);
    wait_lvl(17, 1'b0, 5, n);
    chk_in(n, 0, 4, "clear");
    m = n_meas;
    i_eqp.send(0, EDGE);
    repeat (8) tick();
    chk(n_meas - m, 32'h1, "start measure");
    // gate then edge completion over two channels
    wr_reg(`MTS_ADDR_FORM, 32'h1);
    i_eqp.send(0, EDGE);
    wait_lvl(16, 1'b0, 10, n);
    chk_in(n, 0, 9, "gate raised");
    done(0, 4'h1);
    repeat (20) tick();
    chk(main_out, 32'h0, "gate waits");
    done(0, 4'h2);
    wait_lvl(16, 1'b1, 10, n);
    chk_in(n, 0, 9, "gate ended");
    wr_reg(`MTS_ADDR_FORM, 32'h0);
    done(0, 4'h3);
    wait_lvl(16, 1'b0, 10, n);
    chk_in(n, 0, 9, "completion edge");
    wait_lvl(16, 1'b1, EDGE + 10, n);
    wr_reg(`MTS_ADDR_SDLY, 32'd40);
    done(1, 4'h1);
    repeat (60) tick();
    chk(main_out, 32'h1, "setup waits");
    done(1, 4'h2);
    wait_lvl(16, 1'b0, 60, n);
    chk_in(n, 36, 46, "source delay");
    wait_lvl(16, 1'b1, EDGE + 10, n);
    // step trigger on line 15, step done out on line 3
    wr_reg(`MTS_ADDR_INSRC, (32'd16 << 15) | (32'd15 << 10) | (32'd16 << 5));
    wr_reg(`MTS_ADDR_MDLY, 32'd50);
    wr_reg(`MTS_ADDR_OUTDST, (32'd7 << 15) | (32'd3 << 10));
    m = n_step;
    i_eqp.send(15, EDGE);
    n = 0;
    while (n_step == m && n < 100) begin
      tick();
      n++;
    end
    chk_in(n, 50, 60, "measure delay");
    wr_reg(`MTS_ADDR_MDLY, 32'd2);
    m = n_step;
    i_eqp.send(15, EDGE);
    repeat (12) tick();
    chk(n_step - m, 32'h1, "short measure delay");
    done(2, 4'h3);
    wait_lvl(2, 1'b0, 10, n);
    chk_in(n, 0, 9, "step done");
    chk(gio_oe[2], 32'h1, "line driven");
    cmd(`MTS_CMD_FIRE_SEL);
    wait_lvl(6, 1'b0, 10, n);
    chk_in(n, 0, 9, "fire selected");
    rd_reg(`MTS_ADDR_DONE, d);
    chk(d, 32'h7, "sticky events");
    // pulsed run on line 16
    @(posedge clk);
    pulsed <= 1'b1;
    m = n_setup;
    i_eqp.send(16, EDGE);
    wait_lvl(16, 1'b0, `MTS_PLS_TRIG_CYC + 100, n);
    chk_in(n, `MTS_PLS_TRIG_CYC - 5, `MTS_PLS_TRIG_CYC + 10, "lead out");
    chk(n_setup - m, 32'h1, "start setup");
    m = n_go;
    n = 0;
    while (n_go == m && n < LEAD + 100) begin
      tick();
      n++;
    end
    chk_in(n, LEAD - 5, LEAD + 5, "pulse start");
    wait_lvl(16, 1'b1, `MTS_PULSE_CYC, n);
    tick();
    chk_in(i_eqp.last_low, `MTS_PULSE_CYC - 5, `MTS_PULSE_CYC + 5, "pulse width");
    @(posedge clk);
    pulsed <= 1'b0;
    // timed holds
    wr_reg(`MTS_ADDR_CTRL, 32'h0);
    wr_reg(`MTS_ADDR_HOLD, 32'h2);
    cmd(`MTS_CMD_TIMED);
    repeat (9000) tick();
    chk(hold_busy, 32'h1, "hold counting");
    wait_lvl(17, 1'b0, 11100, n);
    chk_in(n, 900, 11010, "hold timeout");
    wr_reg(`MTS_ADDR_CTRL, 32'h1);
    wr_reg(`MTS_ADDR_HOLD, 32'h00100002);
    cmd(`MTS_CMD_TIMED);
    repeat (25000) tick();
    chk(hold_busy, 32'h1, "no timeout");
    // a frozen block ignores the run command
    @(posedge clk);
    ce <= 1'b0;
    cmd(`MTS_CMD_RUN);
    tick();
    chk(hold_busy, 32'h1, "frozen");
    @(posedge clk);
    ce <= 1'b1;
    cmd(`MTS_CMD_RUN);
    wait_lvl(17, 1'b0, 5, n);
    chk_in(n, 0, 4, "run release");
    cmd(`MTS_CMD_TIMED);
    i_eqp.send(0, EDGE);
    wait_lvl(17, 1'b0, EDGE + 20, n);
    chk(hold_busy, 32'h0, "main release");
    cmd(`MTS_CMD_TIMED_PORT);
    i_eqp.send(16, EDGE);
    wait_lvl(17, 1'b0, EDGE + 20, n);
    chk(hold_busy, 32'h0, "port release");
    give_verdict();
  end
endmodule
`default_nettype wire
